/* common/osa_pkg.sv */
package osa_pkg;

    // ------------------------------------------------------------------
    // register offsets (one address per 32-bit wishbone word, consecutive registers one apart)
    // ------------------------------------------------------------------
    localparam logic [7:0] LINE_HIGH_ADDR = 8'h6e;
    localparam logic [7:0] LINE_LOW_ADDR = 8'h6f;
    localparam logic [7:0] PAR_HIGH_ADDR = 8'h70;
    localparam logic [7:0] PAR_LOW_ADDR = 8'h71;
    localparam logic [7:0] CBIT_HIGH_ADDR = 8'h72;
    localparam logic [7:0] CBIT_LOW_ADDR = 8'h73;
    localparam logic [7:0] CTRL_ADDR = 8'h74;
    localparam logic [7:0] IRQ_STAT_ADDR = 8'h75;
    localparam logic [7:0] IRQ_MASK_ADDR = 8'h76;

    // ------------------------------------------------------------------
    // field layout and reset values
    // ------------------------------------------------------------------
    localparam int CNT_W = 16;
    localparam logic [15:0] CNT_MAX = 16'hffff;
    localparam logic [15:0] CNT_RST = 16'h0000;
    localparam int IRQ_W = 2;
    localparam int IRQ_SECOND_BIT = 0;
    localparam int IRQ_SAT_BIT = 1;
    localparam logic [1:0] IRQ_RST = 2'h0;
    localparam logic [1:0] FMT_RST = 2'h0;
    localparam int FMT_LSB = 0;
    localparam int FMT_MSB = 1;

    // ------------------------------------------------------------------
    // timing: one second at 250 mhz
    // ------------------------------------------------------------------
    localparam int CLK_MHZ = 250;
    localparam int SECOND_S = 1;
    localparam int SECOND_CYCLES = SECOND_S * CLK_MHZ * 1000000;

    // framing formats
    typedef enum logic [1:0] {
        OSA_DS3_CBIT = 2'h0,
        OSA_DS3_M13 = 2'h1,
        OSA_E3_G751 = 2'h3,
        OSA_E3_G832 = 2'h2
    } osa_fmt_type;

    // error strobes from the receive framer, one-cycle pulses
    typedef struct packed {
        logic line_code_violation;
        logic pbit;
        logic bip4;
        logic bip8;
        logic cpbit;
    } osa_err_type;

endpackage : osa_pkg

/* rtl/osa_accum.sv */
`timescale 1ns/1ns
// Function
// - 16-bit line code violation count, 0x6e/0x6f
// - readable values cover last completed second
// - accumulators read-only, writes ignored
// - 16-bit frame parity count, 0x70/0x71
// - ds3 format counts p-bit errors
// - e3 g.751 format counts bip-4 errors
// - e3 g.832 format counts bip-8 errors
// - 16-bit cp-bit error count, 0x72/0x73
// - cp-bit counts only in ds3 c-bit
// - all accumulators read zero after reset
module osa_accum #(
    parameter int SECOND_CYCLES = osa_pkg::SECOND_CYCLES
) (
    // clock and reset
    input wire logic clock_i,
    input wire logic reset_n_i,
    // receive framer events
    input wire osa_pkg::osa_err_type err_i,
    // wishbone slave
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [7:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o,
    // interrupt and tick
    output logic irq_o,
    output logic second_tick_o
);

    // ------------------------------------------------------------------
    // functions
    // ------------------------------------------------------------------
    function automatic logic [15:0] sat_inc(input logic [15:0] v,
                                            input logic ev);
        sat_inc = (ev && v != osa_pkg::CNT_MAX) ? v + 16'h0001 : v;
    endfunction : sat_inc

    // ------------------------------------------------------------------
    // one second timer
    // ------------------------------------------------------------------
    logic [31:0] tick_cnt_r;
    logic tick;
    assign tick = (tick_cnt_r == 32'(SECOND_CYCLES - 1));

    always_ff @(posedge clock_i) begin
        if (!reset_n_i || tick) begin
            tick_cnt_r <= 32'h0;
        end else begin
            tick_cnt_r <= tick_cnt_r + 32'h1;
        end
    end

    always_ff @(posedge clock_i) begin
        if (!reset_n_i) begin
            second_tick_o <= 1'b0;
        end else begin
            second_tick_o <= tick;
        end
    end

    // ------------------------------------------------------------------
    // control register: framing format
    // ------------------------------------------------------------------
    osa_pkg::osa_fmt_type fmt_r;
    logic wr;
    logic rd;
    // writes land on the edge that samples ack high, as the master expects
    // write decode skips counts
    assign wr = wb_cyc_i && wb_stb_i && wb_we_i && wb_ack_o && wb_sel_i[0];
    assign rd = wb_cyc_i && wb_stb_i && !wb_we_i && !wb_ack_o;

    always_ff @(posedge clock_i) begin
        if (!reset_n_i) begin
            fmt_r <= osa_pkg::osa_fmt_type'(osa_pkg::FMT_RST);
        end else if (wr && wb_adr_i == osa_pkg::CTRL_ADDR) begin
            fmt_r <= osa_pkg::osa_fmt_type'(
                wb_dat_i[osa_pkg::FMT_MSB:osa_pkg::FMT_LSB]);
        end
    end

    // ------------------------------------------------------------------
    // event selection
    // ------------------------------------------------------------------
    logic par_ev;
    logic cp_ev;
    always_comb begin
        par_ev = 1'b0;
        unique case (fmt_r)
            osa_pkg::OSA_DS3_CBIT,
            osa_pkg::OSA_DS3_M13: par_ev = err_i.pbit;
            osa_pkg::OSA_E3_G751: par_ev = err_i.bip4;
            osa_pkg::OSA_E3_G832: par_ev = err_i.bip8;
        endcase
    end
    assign cp_ev = err_i.cpbit && fmt_r == osa_pkg::OSA_DS3_CBIT;

    // ------------------------------------------------------------------
    // running counts and accumulators
    // ------------------------------------------------------------------
    logic [15:0] run_r [3];
    logic [15:0] acc_r [3];
    logic [2:0] ev;
    assign ev = {cp_ev, par_ev, err_i.line_code_violation};

    genvar g;
    generate
        for (g = 0; g < 3; g++) begin : g_cnt
            always_ff @(posedge clock_i) begin
                if (!reset_n_i) begin
                    run_r[g] <= osa_pkg::CNT_RST;
                end else if (tick) begin
                    run_r[g] <= sat_inc(osa_pkg::CNT_RST, ev[g]);
                end else begin
                    run_r[g] <= sat_inc(run_r[g], ev[g]);
                end
            end
            // last second only, zero at reset
            always_ff @(posedge clock_i) begin
                if (!reset_n_i) begin
                    acc_r[g] <= osa_pkg::CNT_RST;
                end else if (tick) begin
                    acc_r[g] <= sat_inc(run_r[g], ev[g]);
                end
            end
        end
    endgenerate

    // ------------------------------------------------------------------
    // interrupts: second done, saturated count in finished second
    // ------------------------------------------------------------------
    logic [1:0] stat_r;
    logic [1:0] mask_r;
    logic [1:0] set;
    logic [1:0] clr;
    logic sat_any;
    assign sat_any = (run_r[0] == osa_pkg::CNT_MAX) ||
                     (run_r[1] == osa_pkg::CNT_MAX) ||
                     (run_r[2] == osa_pkg::CNT_MAX);
    assign set = {tick && sat_any, tick};
    assign clr = (wr && wb_adr_i == osa_pkg::IRQ_STAT_ADDR) ?
                 wb_dat_i[1:0] : 2'h0;

    // set wins over a same-cycle clear
    always_ff @(posedge clock_i) begin
        if (!reset_n_i) begin
            stat_r <= osa_pkg::IRQ_RST;
        end else begin
            stat_r <= (stat_r & ~clr) | set;
        end
    end

    always_ff @(posedge clock_i) begin
        if (!reset_n_i) begin
            mask_r <= osa_pkg::IRQ_RST;
        end else if (wr && wb_adr_i == osa_pkg::IRQ_MASK_ADDR) begin
            mask_r <= wb_dat_i[1:0];
        end
    end

    always_ff @(posedge clock_i) begin
        if (!reset_n_i) begin
            irq_o <= 1'b0;
        end else begin
            irq_o <= |(stat_r & mask_r);
        end
    end

    // ------------------------------------------------------------------
    // wishbone read path; accumulators have no write decode at all
    // ------------------------------------------------------------------
    logic [7:0] rd_byte;
    always_comb begin
        rd_byte = 8'h00;
        unique case (wb_adr_i)
            osa_pkg::LINE_HIGH_ADDR: rd_byte = acc_r[0][15:8];
            osa_pkg::LINE_LOW_ADDR: rd_byte = acc_r[0][7:0];
            osa_pkg::PAR_HIGH_ADDR: rd_byte = acc_r[1][15:8];
            osa_pkg::PAR_LOW_ADDR: rd_byte = acc_r[1][7:0];
            osa_pkg::CBIT_HIGH_ADDR: rd_byte = acc_r[2][15:8];
            osa_pkg::CBIT_LOW_ADDR: rd_byte = acc_r[2][7:0];
            osa_pkg::CTRL_ADDR: rd_byte = {6'h00, fmt_r};
            osa_pkg::IRQ_STAT_ADDR: rd_byte = {6'h00, stat_r};
            osa_pkg::IRQ_MASK_ADDR: rd_byte = {6'h00, mask_r};
            default: rd_byte = 8'h00;
        endcase
    end

    // one wait state: ack the cycle after the strobe, drop it next cycle
    always_ff @(posedge clock_i) begin
        if (!reset_n_i) begin
            wb_ack_o <= 1'b0;
        end else begin
            wb_ack_o <= wb_cyc_i && wb_stb_i && !wb_ack_o;
        end
    end

    always_ff @(posedge clock_i) begin
        if (!reset_n_i) begin
            wb_dat_o <= 32'h0;
        end else if (rd) begin
            wb_dat_o <= {24'h000000, rd_byte};
        end
    end

    // ------------------------------------------------------------------
    // assertions
    // ------------------------------------------------------------------
    a_acc_transfer: assert property (
        @(posedge clock_i) disable iff (!reset_n_i)
        tick |=> acc_r[0] == ($past(run_r[0]) == osa_pkg::CNT_MAX ?
            osa_pkg::CNT_MAX : $past(run_r[0]) + 16'($past(ev[0]))))
        else $error("line code accumulator not loaded at tick");
    a_acc_hold: assert property (
        @(posedge clock_i) disable iff (!reset_n_i)
        !tick |=> $stable(acc_r[1]))
        else $error("parity accumulator changed mid second");
    a_run_restart: assert property (
        @(posedge clock_i) disable iff (!reset_n_i)
        tick && !ev[2] |=> run_r[2] == 16'h0000)
        else $error("running count not restarted");
    a_sat_hold: assert property (
        @(posedge clock_i) disable iff (!reset_n_i)
        !tick && run_r[0] == osa_pkg::CNT_MAX |=> run_r[0] == osa_pkg::CNT_MAX)
        else $error("count wrapped");
    a_cbit_gate: assert property (
        @(posedge clock_i) disable iff (!reset_n_i)
        !tick && fmt_r != osa_pkg::OSA_DS3_CBIT |=> $stable(run_r[2]))
        else $error("cp-bit counted outside c-bit");
    a_pbit_count: assert property (
        @(posedge clock_i) disable iff (!reset_n_i)
        !tick && fmt_r == osa_pkg::OSA_DS3_M13 && err_i.pbit &&
        run_r[1] != osa_pkg::CNT_MAX |=> run_r[1] == $past(run_r[1]) + 16'h1)
        else $error("p-bit not counted");
    a_bip4_count: assert property (
        @(posedge clock_i) disable iff (!reset_n_i)
        !tick && fmt_r == osa_pkg::OSA_E3_G751 && !err_i.bip4 |=>
        $stable(run_r[1]))
        else $error("g751 counted without bip-4");
    a_bip8_count: assert property (
        @(posedge clock_i) disable iff (!reset_n_i)
        !tick && fmt_r == osa_pkg::OSA_E3_G832 && err_i.bip8 &&
        run_r[1] != osa_pkg::CNT_MAX |=> run_r[1] == $past(run_r[1]) + 16'h1)
        else $error("bip-8 not counted");
    a_read_only: assert property (
        @(posedge clock_i) disable iff (!reset_n_i)
        wr && !tick && wb_adr_i == osa_pkg::LINE_LOW_ADDR |=>
        $stable(acc_r[0]))
        else $error("write altered accumulator");
    a_reset_zero: assert property (
        @(posedge clock_i)
        !reset_n_i |=> acc_r[0] == 16'h0 && acc_r[1] == 16'h0 &&
        acc_r[2] == 16'h0)
        else $error("accumulator not zero after reset");
    a_ack_pulse: assert property (
        @(posedge clock_i) disable iff (!reset_n_i)
        wb_ack_o |=> !wb_ack_o)
        else $error("ack longer than one cycle");

    // ------------------------------------------------------------------
    // assertions: timer and running counts
    // ------------------------------------------------------------------
    a_tick_bound: assert property (
        @(posedge clock_i) disable iff (!reset_n_i)
        tick_cnt_r < 32'(SECOND_CYCLES))
        else $error("second timer ran past its period");
    a_tick_out: assert property (
        @(posedge clock_i) disable iff (!reset_n_i)
        1'b1 |=> second_tick_o == $past(tick))
        else $error("second tick output out of step");
    a_line_count: assert property (
        @(posedge clock_i) disable iff (!reset_n_i)
        !tick && err_i.line_code_violation &&
        run_r[0] != osa_pkg::CNT_MAX |=> run_r[0] == $past(run_r[0]) + 16'h1)
        else $error("line code violation not counted");
    a_line_idle: assert property (
        @(posedge clock_i) disable iff (!reset_n_i)
        !tick && !err_i.line_code_violation |=> $stable(run_r[0]))
        else $error("line count moved without an event");
    a_cbit_count: assert property (
        @(posedge clock_i) disable iff (!reset_n_i)
        !tick && fmt_r == osa_pkg::OSA_DS3_CBIT && err_i.cpbit &&
        run_r[2] != osa_pkg::CNT_MAX |=> run_r[2] == $past(run_r[2]) + 16'h1)
        else $error("cp-bit error not counted");
    a_pbit_idle: assert property (
        @(posedge clock_i) disable iff (!reset_n_i)
        !tick && fmt_r == osa_pkg::OSA_DS3_CBIT && !err_i.pbit |=>
        $stable(run_r[1]))
        else $error("c-bit parity counted without p-bit");
    a_line_restart: assert property (
        @(posedge clock_i) disable iff (!reset_n_i)
        tick && !ev[0] |=> run_r[0] == 16'h0000)
        else $error("line running count not restarted");
    a_par_restart: assert property (
        @(posedge clock_i) disable iff (!reset_n_i)
        tick && !ev[1] |=> run_r[1] == 16'h0000)
        else $error("parity running count not restarted");
    a_sat_par: assert property (
        @(posedge clock_i) disable iff (!reset_n_i)
        !tick && run_r[1] == osa_pkg::CNT_MAX |=> run_r[1] == osa_pkg::CNT_MAX)
        else $error("parity count wrapped");
    a_sat_cbit: assert property (
        @(posedge clock_i) disable iff (!reset_n_i)
        !tick && run_r[2] == osa_pkg::CNT_MAX |=> run_r[2] == osa_pkg::CNT_MAX)
        else $error("cp-bit count wrapped");

    // ------------------------------------------------------------------
    // assertions: accumulators, interrupts and bus
    // ------------------------------------------------------------------
    a_par_transfer: assert property (
        @(posedge clock_i) disable iff (!reset_n_i)
        tick |=> acc_r[1] == ($past(run_r[1]) == osa_pkg::CNT_MAX ?
            osa_pkg::CNT_MAX : $past(run_r[1]) + 16'($past(ev[1]))))
        else $error("parity accumulator not loaded at tick");
    a_acc_steady: assert property (
        @(posedge clock_i) disable iff (!reset_n_i)
        !tick |=> $stable(acc_r[0]) && $stable(acc_r[2]))
        else $error("accumulator changed mid second");
    a_fmt_write: assert property (
        @(posedge clock_i) disable iff (!reset_n_i)
        wr && wb_adr_i == osa_pkg::CTRL_ADDR |=>
        fmt_r == $past(wb_dat_i[osa_pkg::FMT_MSB:osa_pkg::FMT_LSB]))
        else $error("framing format not written");
    a_mask_write: assert property (
        @(posedge clock_i) disable iff (!reset_n_i)
        wr && wb_adr_i == osa_pkg::IRQ_MASK_ADDR |=>
        mask_r == $past(wb_dat_i[1:0]))
        else $error("interrupt mask not written");
    a_stat_set: assert property (
        @(posedge clock_i) disable iff (!reset_n_i)
        tick |=> stat_r[osa_pkg::IRQ_SECOND_BIT])
        else $error("second status bit not set");
    a_irq_level: assert property (
        @(posedge clock_i) disable iff (!reset_n_i)
        1'b1 |=> irq_o == $past(|(stat_r & mask_r)))
        else $error("interrupt output out of step");
    a_ack_answer: assert property (
        @(posedge clock_i) disable iff (!reset_n_i)
        wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
        else $error("bus request not acknowledged");
    a_read_upper: assert property (
        @(posedge clock_i) disable iff (!reset_n_i)
        wb_ack_o |-> wb_dat_o[31:8] == 24'h000000)
        else $error("read data upper bits not zero");

endmodule : osa_accum

/* verif/test_osa_accum.sv */
`timescale 1ns/1ns
module test_osa_accum;
    // ------------------------------------------------------------------
    // signals
    // ------------------------------------------------------------------
    // short second keeps the run small; expectations do not depend on it
    localparam int SEC = 64;
    localparam logic [7:0] HI [3] = '{osa_pkg::LINE_HIGH_ADDR,
        osa_pkg::PAR_HIGH_ADDR, osa_pkg::CBIT_HIGH_ADDR};
    localparam logic [7:0] LO [3] = '{osa_pkg::LINE_LOW_ADDR,
        osa_pkg::PAR_LOW_ADDR, osa_pkg::CBIT_LOW_ADDR};
    localparam osa_pkg::osa_fmt_type FMTS [4] = '{osa_pkg::OSA_DS3_CBIT,
        osa_pkg::OSA_DS3_M13, osa_pkg::OSA_E3_G751, osa_pkg::OSA_E3_G832};
    localparam logic [15:0] PEXP [4] = '{16'h2, 16'h2, 16'h3, 16'h4};
    localparam logic [15:0] CEXP [4] = '{16'h5, 16'h0, 16'h0, 16'h0};
    logic clock_i = 1'b0;
    logic reset_n_i = 1'b0;
    osa_pkg::osa_err_type err_i = '0;
    logic wb_cyc_i = 1'b0;
    logic wb_stb_i = 1'b0;
    logic wb_we_i = 1'b0;
    logic [7:0] wb_adr_i = 8'h00;
    logic [3:0] wb_sel_i = 4'h0;
    logic [31:0] wb_dat_i = 32'h0;
    logic [31:0] wb_dat_o;
    logic wb_ack_o;
    logic irq_o;
    logic second_tick_o;
    logic [31:0] rd;
    int errors = 0;
    int n_tests = 0;
    int cycles = 0;

    always #2 clock_i = ~clock_i;

    osa_accum #(.SECOND_CYCLES(SEC)) osa_accum_i (
        .clock_i(clock_i), .reset_n_i(reset_n_i), .err_i(err_i),
        .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i),
        .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i),
        .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .irq_o(irq_o),
        .second_tick_o(second_tick_o));

    // ------------------------------------------------------------------
    // tasks
    // ------------------------------------------------------------------
    task automatic end_of_test();
        $display("checks %0d, mismatches %0d", n_tests, errors);
        if (errors == 0 && n_tests > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask : end_of_test

    task automatic check(input logic [31:0] seen, input logic [31:0] exp,
                         input string msg);
        n_tests++;
        if (seen !== exp) begin
            errors++;
            $display("CHECK FAILED at %0t: %s got %h want %h", $time, msg,
                     seen, exp);
        end
    endtask : check

    // request held until ack is sampled high, then released for a cycle
    task automatic wb(input logic we, input logic [7:0] adr,
                      input logic [31:0] dat);
        wb_cyc_i <= 1'b1;
        wb_stb_i <= 1'b1;
        wb_we_i <= we;
        wb_adr_i <= adr;
        wb_sel_i <= 4'hf;
        wb_dat_i <= dat;
        do begin
            @(posedge clock_i);
        end while (wb_ack_o !== 1'b1);
        check({31'h0, wb_ack_o}, 32'h1, "bus ack");
        rd = wb_dat_o;
        wb_cyc_i <= 1'b0;
        wb_stb_i <= 1'b0;
        wb_we_i <= 1'b0;
        @(posedge clock_i);
    endtask : wb

    task automatic rdchk(input logic [7:0] adr, input logic [7:0] exp,
                         input string msg);
        wb(1'b0, adr, 32'h0);
        check(rd, {24'h0, exp}, msg);
    endtask : rdchk

    task automatic cnt(input int k, input logic [15:0] exp, input string msg);
        rdchk(HI[k], exp[15:8], msg);
        rdchk(LO[k], exp[7:0], msg);
    endtask : cnt

    task automatic all_zero(input string msg);
        for (int k = 0; k < 3; k++) begin
            cnt(k, 16'h0, msg);
        end
    endtask : all_zero

    task automatic wait_tick();
        int n;
        n = 0;
        do begin
            @(posedge clock_i);
            n++;
        end while (second_tick_o !== 1'b1 && n < 2 * SEC);
        check({31'h0, second_tick_o}, 32'h1, "second tick");
    endtask : wait_tick

    // 1 line code, 2 pbit, 3 bip4, 4 bip8, 5 cpbit events
    task automatic burst();
        for (int i = 0; i < 5; i++) begin
            err_i <= '{line_code_violation: i < 1, pbit: i < 2, bip4: i < 3,
                       bip8: i < 4, cpbit: i < 5};
            @(posedge clock_i);
        end
        err_i <= '0;
    endtask : burst

    always @(posedge clock_i) begin
        cycles <= cycles + 1;
        if (cycles == 5000) begin
            errors++;
            end_of_test();
        end
    end

    // ------------------------------------------------------------------
    // tests
    // ------------------------------------------------------------------
    initial begin
        repeat (16) @(posedge clock_i);
        reset_n_i <= 1'b1;
        @(posedge clock_i);
        all_zero("reset value");
        rdchk(8'h00, 8'h00, "unmapped read");
        $display("test reset done");
        for (int f = 0; f < 4; f++) begin
            wait_tick();
            wb(1'b1, osa_pkg::CTRL_ADDR, {30'h0, FMTS[f]});
            burst();
            // running counts must not show until the second closes
            cnt(0, 16'h0, "mid second");
            wait_tick();
            cnt(0, 16'h1, "line count");
            cnt(1, PEXP[f], "parity count");
            cnt(2, CEXP[f], "cbit count");
            $display("test format %0d done", f);
        end
        // writes to counts must leave them as they were
        wb(1'b1, osa_pkg::LINE_LOW_ADDR, 32'hff);
        wb(1'b1, osa_pkg::PAR_HIGH_ADDR, 32'hff);
        cnt(0, 16'h1, "line after write");
        cnt(1, 16'h4, "parity after write");
        $display("test read only done");
        wait_tick();
        all_zero("quiet second");
        $display("test quiet second done");
        wb(1'b1, osa_pkg::IRQ_STAT_ADDR, 32'h3);
        rdchk(osa_pkg::IRQ_STAT_ADDR, 8'h00, "status cleared");
        wb(1'b1, osa_pkg::IRQ_MASK_ADDR, 32'h1);
        @(posedge clock_i);
        check({31'h0, irq_o}, 32'h0, "irq idle");
        wait_tick();
        @(posedge clock_i);
        check({31'h0, irq_o}, 32'h1, "irq raised");
        rdchk(osa_pkg::IRQ_STAT_ADDR, 8'h01, "status set");
        wb(1'b1, osa_pkg::IRQ_MASK_ADDR, 32'h0);
        @(posedge clock_i);
        check({31'h0, irq_o}, 32'h0, "irq masked");
        $display("test interrupt done");
        end_of_test();
    end
endmodule : test_osa_accum
